/* rtl/gbp_pkg.sv */
// Package for the bit and byte GPIO port block
// Assumes one clock and a synchronous active-high reset
package gbp_pkg;

  // ************************************************************
  // Geometry and reset values
  // ************************************************************
  localparam int unsigned PORT_W = 8;
  localparam int unsigned NUM_PORTS = 2;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;

  // ************************************************************
  // Commands
  // ************************************************************
  typedef enum logic [3:0] {
    GBP_NOP,
    GBP_PIN_HIGH,
    GBP_PIN_LOW,
    GBP_PIN_INVERT,
    GBP_PIN_WRITE,
    GBP_PIN_MASK,
    GBP_PIN_TEST_HIGH,
    GBP_PIN_TEST_LOW,
    GBP_PIN_INPUT,
    GBP_PIN_OUTPUT,
    GBP_PORT_INPUT,
    GBP_PORT_OUTPUT,
    GBP_PORT_WRITE,
    GBP_PORT_READ
  } gbp_cmd_t;

  typedef struct packed {
    logic valid;
    gbp_cmd_t cmd;
    logic port_sel;
    logic [2:0] bit_sel;
    logic [15:0] value;
  } gbp_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic flag;
  } gbp_rsp_t;

endpackage : gbp_pkg

/* rtl/gbp_port.sv */
// Bit and byte GPIO port block: two 8-pin ports driven by commands
// Assumes pin inputs synchronous to mclk; pad resolves wire from oe
//
// Operation
// - Drive-high: pin becomes output, drives one
// - Drive-low: pin becomes output, drives zero
// - Invert: pin becomes output, driven level flips
// - Value-write latches one for any nonzero value, zero for zero; direction unchanged
// - Mask read: pin to input, level returned at its bit position
// - High/low test: pin to input, true on matching level
// - Pin make-input disables its driver
// - Pin make-output enables driver with unchanged latched level
// - Port make-input sets all eight pins to input
// - Port make-output enables all drivers, latches unchanged
// - Byte write: port to output, drives given byte
// - Byte read: port to input, returns eight sampled levels
`timescale 1ns/1ps
module gbp_port #(
  parameter int unsigned PORTS = gbp_pkg::NUM_PORTS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Command and answer
  input wire gbp_pkg::gbp_req_t req,
  output gbp_pkg::gbp_rsp_t rsp,
  // Pins
  input wire logic [PORTS*gbp_pkg::PORT_W-1:0] pin_in,
  output logic [PORTS*gbp_pkg::PORT_W-1:0] pin_out,
  output logic [PORTS*gbp_pkg::PORT_W-1:0] pin_oe
);

  localparam int unsigned W = gbp_pkg::PORT_W;

  // Port select is one bit wide, so only two ports can be served
  if (PORTS != 2) begin : g_bad_ports
    $error("gbp_port serves exactly two ports");
  end

  // ************************************************************
  // Per-bit state
  // ************************************************************
  logic [PORTS-1:0][W-1:0] dir_q, dir_d;
  logic [PORTS-1:0][W-1:0] latch_q, latch_d;
  gbp_pkg::gbp_rsp_t rsp_q, rsp_d;

  logic p;
  logic [2:0] b;
  logic [W-1:0] onehot;
  logic [W-1:0] cur_in;
  logic sel_in;
  logic nz;

  assign p = req.port_sel;
  assign b = req.bit_sel;
  assign onehot = 8'h01 << b;
  assign cur_in = pin_in[p*W +: W];
  assign sel_in = cur_in[b];
  assign nz = |req.value;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    dir_d = dir_q;
    latch_d = latch_q;
    rsp_d = '0;
    if (req.valid) begin
      case (req.cmd)
        gbp_pkg::GBP_PIN_HIGH: begin
          dir_d[p][b] = 1'b1;
          latch_d[p][b] = 1'b1;
        end
        gbp_pkg::GBP_PIN_LOW: begin
          dir_d[p][b] = 1'b1;
          latch_d[p][b] = 1'b0;
        end
        gbp_pkg::GBP_PIN_INVERT: begin
          dir_d[p][b] = 1'b1;
          latch_d[p][b] = ~latch_q[p][b];
        end
        gbp_pkg::GBP_PIN_WRITE: begin
          // Stores the level only; direction is left as it was
          latch_d[p][b] = nz;
        end
        gbp_pkg::GBP_PIN_MASK: begin
          dir_d[p][b] = 1'b0;
          rsp_d.valid = 1'b1;
          rsp_d.data = cur_in & onehot;
          rsp_d.flag = sel_in;
        end
        gbp_pkg::GBP_PIN_TEST_HIGH: begin
          dir_d[p][b] = 1'b0;
          rsp_d.valid = 1'b1;
          rsp_d.flag = sel_in;
        end
        gbp_pkg::GBP_PIN_TEST_LOW: begin
          dir_d[p][b] = 1'b0;
          rsp_d.valid = 1'b1;
          rsp_d.flag = ~sel_in;
        end
        gbp_pkg::GBP_PIN_INPUT: dir_d[p][b] = 1'b0;
        gbp_pkg::GBP_PIN_OUTPUT: dir_d[p][b] = 1'b1;
        gbp_pkg::GBP_PORT_INPUT: dir_d[p] = '0;
        gbp_pkg::GBP_PORT_OUTPUT: dir_d[p] = '1;
        gbp_pkg::GBP_PORT_WRITE: begin
          dir_d[p] = '1;
          latch_d[p] = req.value[W-1:0];
        end
        gbp_pkg::GBP_PORT_READ: begin
          dir_d[p] = '0;
          rsp_d.valid = 1'b1;
          rsp_d.data = cur_in;
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < PORTS; i++) begin
        dir_q[i] <= gbp_pkg::RST_DIR;
        latch_q[i] <= gbp_pkg::RST_LATCH;
      end
      rsp_q <= '0;
    end else begin
      dir_q <= dir_d;
      latch_q <= latch_d;
      rsp_q <= rsp_d;
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_pins
      // Own flops per port, so each pin comes straight from a register
      logic [W-1:0] out_q;
      logic [W-1:0] oe_q;
      always_ff @(posedge mclk) begin
        if (reset) begin
          out_q <= gbp_pkg::RST_LATCH;
          oe_q <= gbp_pkg::RST_DIR;
        end else begin
          out_q <= latch_d[g];
          oe_q <= dir_d[g];
        end
      end
      assign pin_out[g*W +: W] = out_q;
      assign pin_oe[g*W +: W] = oe_q;
    end
  endgenerate

  assign rsp = rsp_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_high_drives: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_HIGH |=>
      pin_oe[$past(p)*W + $past(b)] && pin_out[$past(p)*W + $past(b)])
    else $error("drive-high did not drive one");
  chk_low_drives: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_LOW |=>
      pin_oe[$past(p)*W + $past(b)] && !pin_out[$past(p)*W + $past(b)])
    else $error("drive-low did not drive zero");
  chk_invert_flips: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_INVERT |=>
      pin_out[$past(p)*W + $past(b)] != $past(latch_q[p][b]))
    else $error("invert did not flip level");
  chk_write_nonzero: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_WRITE |=>
      latch_q[$past(p)][$past(b)] == ($past(req.value) != 16'h0000))
    else $error("value write wrong level");

  // ************************************************************
  // Checks: answers, port direction, byte write and reset
  // ************************************************************
  chk_mask_pos: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_MASK |=>
      rsp.valid && rsp.data == ($past(cur_in) & (8'h01 << $past(b))))
    else $error("mask read wrong");
  chk_test_low: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_TEST_LOW |=>
      rsp.valid && rsp.flag == !$past(sel_in))
    else $error("low test wrong");
  chk_port_input: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_INPUT |=>
      pin_oe[$past(p)*W +: W] == 8'h00)
    else $error("port input left drivers on");
  chk_port_output: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_OUTPUT |=>
      pin_oe[$past(p)*W +: W] == 8'hff && $stable(latch_q))
    else $error("port output wrong");
  chk_byte_write: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_WRITE |=>
      pin_out[$past(p)*W +: W] == $past(req.value[7:0]))
    else $error("byte write wrong");
  chk_byte_read: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_READ |=>
      rsp.valid && rsp.data == $past(cur_in))
    else $error("byte read wrong");
  chk_reset_input: assert property (
    @(posedge mclk) disable iff (1'b0) $past(reset) |-> pin_oe == '0 && pin_out == '0)
    else $error("reset left pins driven");
  chk_reset_answer: assert property (
    @(posedge mclk) disable iff (1'b0) $past(reset) |-> rsp == '0)
    else $error("reset left an answer standing");

  // ************************************************************
  // Checks: high test, direction, isolation and latch
  // ************************************************************
  chk_test_high: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_TEST_HIGH |=>
      rsp.valid && rsp.flag == $past(sel_in))
    else $error("high test wrong");
  chk_test_input: assert property (
    req.valid && req.cmd inside {gbp_pkg::GBP_PIN_TEST_HIGH,
      gbp_pkg::GBP_PIN_TEST_LOW} |=>
      !pin_oe[$past(p)*W + $past(b)])
    else $error("level test left the driver on");
  chk_mask_input: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_MASK |=>
      !pin_oe[$past(p)*W + $past(b)] && rsp.flag == $past(sel_in))
    else $error("mask read left the driver on");
  chk_pin_input: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_INPUT |=>
      !pin_oe[$past(p)*W + $past(b)])
    else $error("make-input left the driver on");
  chk_pin_output: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_OUTPUT |=>
      pin_oe[$past(p)*W + $past(b)] && $stable(latch_q) &&
      pin_out[$past(p)*W + $past(b)] == $past(latch_q[p][b]))
    else $error("make-output wrong");
  chk_invert_output: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_INVERT |=>
      pin_oe[$past(p)*W + $past(b)])
    else $error("invert left the pin an input");
  chk_value_keeps_dir: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_WRITE |=> $stable(pin_oe))
    else $error("value write changed direction");
  chk_write_output: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_WRITE |=>
      pin_oe[$past(p)*W +: W] == 8'hff)
    else $error("byte write left pins input");
  chk_read_input: assert property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_READ |=>
      pin_oe[$past(p)*W +: W] == 8'h00)
    else $error("byte read left drivers on");
  chk_byte_silent: assert property (
    req.valid && req.cmd inside {gbp_pkg::GBP_PORT_INPUT, gbp_pkg::GBP_PORT_OUTPUT,
      gbp_pkg::GBP_PORT_WRITE} |=> !rsp.valid)
    else $error("byte command without read answered");
  chk_input_keeps_latch: assert property (
    req.valid && req.cmd inside {gbp_pkg::GBP_PIN_INPUT, gbp_pkg::GBP_PORT_INPUT} |=>
      $stable(latch_q))
    else $error("make-input changed the latch");
  chk_read_keeps_latch: assert property (
    req.valid && req.cmd inside {gbp_pkg::GBP_PIN_MASK, gbp_pkg::GBP_PIN_TEST_HIGH,
      gbp_pkg::GBP_PIN_TEST_LOW, gbp_pkg::GBP_PORT_READ} |=>
      $stable(latch_q))
    else $error("read changed the latch");
  chk_bit_isolated: assert property (
    req.valid && req.cmd inside {gbp_pkg::GBP_PIN_HIGH, gbp_pkg::GBP_PIN_LOW,
      gbp_pkg::GBP_PIN_INVERT, gbp_pkg::GBP_PIN_WRITE} |=>
      (latch_q[$past(p)] & ~$past(onehot)) == ($past(latch_q[p]) & ~$past(onehot)))
    else $error("bit command disturbed its neighbours");
  chk_other_port: assert property (
    req.valid |=> pin_oe[(!$past(p))*W +: W] == $past(pin_oe[(!p)*W +: W]) &&
      pin_out[(!$past(p))*W +: W] == $past(pin_out[(!p)*W +: W]))
    else $error("command reached the other port");
  chk_quiet_hold: assert property (
    !req.valid |=> $stable(pin_oe) && $stable(pin_out) && !rsp.valid)
    else $error("idle cycle changed the pins");

  // ************************************************************
  // Cover points
  // ************************************************************
  cov_toggle_twice: cover property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_INVERT ##1
    req.valid && req.cmd == gbp_pkg::GBP_PIN_INVERT);
  cov_byte_then_bit: cover property (
    req.valid && req.cmd == gbp_pkg::GBP_PORT_WRITE ##1
    req.valid && req.cmd == gbp_pkg::GBP_PIN_MASK);
  cov_input_output: cover property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_INPUT ##[1:4]
    req.valid && req.cmd == gbp_pkg::GBP_PIN_OUTPUT);
  cov_test_low_true: cover property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_TEST_LOW ##1 rsp.flag);
  cov_write_upper: cover property (
    req.valid && req.cmd == gbp_pkg::GBP_PIN_WRITE && req.value[7:0] == 8'h00 &&
    req.value != 16'h0000);

endmodule : gbp_port

/* tb/gbp_pins.sv */
// Far-side pin model: lamps and switches on both byte ports
// Assumes pin_oe high means the block drives that pin
`timescale 1ns/1ps
module gbp_pins (
  // Block side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  // Switch levels set by the bench
  input wire logic [15:0] ext_level,
  // Level seen back by the block
  output logic [15:0] pin_in
);
  // Driven pins read back their own level, so a read can see an output
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : gbp_pins

/* tb/gbp_port_tb.sv */
// Testbench for the bit and byte GPIO port block
// Assumes the pin model closes the loop from pin_out back to pin_in
`timescale 1ns/1ps
module gbp_port_tb;
  logic mclk;
  logic reset;
  gbp_pkg::gbp_req_t req;
  gbp_pkg::gbp_rsp_t rsp;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] ext_level;
  int fails;
  int checks_done;

  gbp_port u_dut (.mclk(mclk), .reset(reset), .req(req), .rsp(rsp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  gbp_pins u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Expected: {valid, flag, data, oe, out} of the selected port
  task automatic step(input gbp_pkg::gbp_cmd_t c, input logic p, input logic [2:0] b,
      input logic [15:0] v, input logic [31:0] exp);
    logic f;
    logic [7:0] d;
    @(negedge mclk);
    req = '{1'b1, c, p, b, v};
    @(negedge mclk);
    req.valid = 1'b0;
    f = rsp.valid && c != gbp_pkg::GBP_PORT_READ && rsp.flag;
    d = (c inside {gbp_pkg::GBP_PIN_MASK, gbp_pkg::GBP_PORT_READ}) ? rsp.data : 8'h00;
    chk({6'h00, rsp.valid, f, d, pin_oe[p*8+:8], pin_out[p*8+:8]}, exp);
  endtask : step

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    chk({pin_oe, pin_out}, 32'h00000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bytes;
    step(gbp_pkg::GBP_PORT_WRITE, 1'b0, 3'h0, 16'h0055, 32'h0000ff55);
    step(gbp_pkg::GBP_PORT_INPUT, 1'b0, 3'h0, 16'h0000, 32'h00000055);
    step(gbp_pkg::GBP_PORT_OUTPUT, 1'b0, 3'h0, 16'h0000, 32'h0000ff55);
    step(gbp_pkg::GBP_PIN_HIGH, 1'b0, 3'h1, 16'h0000, 32'h0000ff57);
    step(gbp_pkg::GBP_PORT_WRITE, 1'b1, 3'h0, 16'h003c, 32'h0000ff3c);
    // First read still samples the driven level of that cycle
    step(gbp_pkg::GBP_PORT_READ, 1'b1, 3'h0, 16'h0000, 32'h023c003c);
    step(gbp_pkg::GBP_PORT_READ, 1'b1, 3'h0, 16'h0000, 32'h02a5003c);
    $display("test bytes done");
  endtask : t_bytes

  task automatic t_pins;
    step(gbp_pkg::GBP_PIN_HIGH, 1'b1, 3'h0, 16'h0000, 32'h0000013d);
    step(gbp_pkg::GBP_PIN_INVERT, 1'b1, 3'h0, 16'h0000, 32'h0000013c);
    step(gbp_pkg::GBP_PIN_INVERT, 1'b1, 3'h6, 16'h0000, 32'h0000417c);
    step(gbp_pkg::GBP_PIN_LOW, 1'b1, 3'h2, 16'h0000, 32'h00004578);
    step(gbp_pkg::GBP_PIN_WRITE, 1'b1, 3'h1, 16'h0100, 32'h0000457a);
    step(gbp_pkg::GBP_PIN_WRITE, 1'b1, 3'h1, 16'h0000, 32'h00004578);
    step(gbp_pkg::GBP_PIN_INPUT, 1'b1, 3'h6, 16'h0000, 32'h00000578);
    step(gbp_pkg::GBP_PIN_OUTPUT, 1'b1, 3'h6, 16'h0000, 32'h00004578);
    $display("test pins done");
  endtask : t_pins

  task automatic t_reads;
    step(gbp_pkg::GBP_PIN_MASK, 1'b1, 3'h2, 16'h0000, 32'h02004178);
    step(gbp_pkg::GBP_PIN_MASK, 1'b1, 3'h2, 16'h0000, 32'h03044178);
    step(gbp_pkg::GBP_PIN_TEST_HIGH, 1'b1, 3'h7, 16'h0000, 32'h03004178);
    step(gbp_pkg::GBP_PIN_TEST_LOW, 1'b1, 3'h3, 16'h0000, 32'h03004178);
    step(gbp_pkg::GBP_PIN_TEST_LOW, 1'b1, 3'h6, 16'h0000, 32'h02000178);
    step(gbp_pkg::GBP_NOP, 1'b1, 3'h0, 16'hffff, 32'h00000178);
    chk({pin_oe, pin_out}, 32'h01ff7857);
    $display("test reads done");
  endtask : t_reads

  // Reset with pins driven: latches must come back cleared, not just hidden
  task automatic t_rereset;
    @(negedge mclk);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    chk({pin_oe, pin_out}, 32'h00000000);
    chk({22'h0, rsp}, 32'h00000000);
    step(gbp_pkg::GBP_PORT_OUTPUT, 1'b1, 3'h0, 16'h0000, 32'h0000ff00);
    step(gbp_pkg::GBP_PORT_OUTPUT, 1'b0, 3'h0, 16'h0000, 32'h0000ff00);
    step(gbp_pkg::GBP_PORT_READ, 1'b1, 3'h0, 16'h0000, 32'h02000000);
    $display("test reset again done");
  endtask : t_rereset

  initial begin
    reset = 1'b1;
    req = '0;
    ext_level = 16'ha500;
    fails = 0;
    checks_done = 0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_bytes();
    t_pins();
    t_reads();
    t_rereset();
    close_out();
  end
endmodule : gbp_port_tb
